// ---- design/asw_pkg.sv ----
package asw_pkg;

  // ----------------------------------------------------------------
  // Word geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;

  // ----------------------------------------------------------------
  // Alarm word bit positions
  // ----------------------------------------------------------------
  localparam int ALM_POS_LIMIT  = 0;
  localparam int ALM_CCW_LIMIT  = 1;
  localparam int ALM_CW_LIMIT   = 2;
  localparam int ALM_OVER_TEMP  = 3;
  localparam int ALM_INT_VOLT   = 4;
  localparam int ALM_OVER_VOLT  = 5;
  localparam int ALM_UNDER_VOLT = 6;
  localparam int ALM_OVER_CURR  = 7;
  localparam int ALM_HALL_WIND  = 8;
  localparam int ALM_ENCODER    = 9;
  localparam int ALM_COMM_ERR   = 10;
  localparam int ALM_BAD_FLASH  = 11;

  // Alarm bits that are drive faults and disable the motor.
  localparam logic [15:0] ALM_FAULT_MASK = 16'h0BA8;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int STS_ENABLED    = 0;
  localparam int STS_SAMPLING   = 1;
  localparam int STS_FAULT      = 2;
  localparam int STS_IN_POS     = 3;
  localparam int STS_MOVING     = 4;
  localparam int STS_JOGGING    = 5;
  localparam int STS_STOPPING   = 6;
  localparam int STS_WAIT_INPUT = 7;
  localparam int STS_SAVING     = 8;
  localparam int STS_ALARM      = 9;
  localparam int STS_HOMING     = 10;
  localparam int STS_WAIT_TIME  = 11;
  localparam int STS_WIZARD     = 12;
  localparam int STS_ENC_CHECK  = 13;
  localparam int STS_PROGRAM    = 14;
  localparam int STS_INIT       = 15;

  // ----------------------------------------------------------------
  // Reply characters (ASCII)
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_EQUALS  = 8'h3D;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_HEX_A   = 8'h37;   // 'A' minus ten.
  localparam logic [7:0] CH_CR      = 8'h0D;

  // Prefix characters echoed before the value.
  localparam logic [7:0] ALM_PFX0 = 8'h41;
  localparam logic [7:0] ALM_PFX1 = 8'h4C;
  localparam logic [7:0] STS_PFX0 = 8'h53;
  localparam logic [7:0] STS_PFX1 = 8'h43;
  localparam logic [7:0] RD_PFX0  = 8'h52;
  localparam logic [7:0] RD_PFX1  = 8'h4C;
  localparam logic [7:0] ALM_REG  = 8'h66;
  localparam logic [7:0] STS_REG  = 8'h73;

  // Number of decimal digits for a 16-bit value.
  localparam int DEC_DIGITS = 5;

  // ----------------------------------------------------------------
  // Query kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ASW_QRY_ALARM_HEX,
    ASW_QRY_STATE_HEX,
    ASW_QRY_ALARM_DEC,
    ASW_QRY_STATE_DEC
  } asw_query_t;

endpackage

// ---- design/asw_sync.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser for a bundle of asynchronous levels.
module asw_sync #(
  parameter int W = 16
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // The first stage feeds only the second one.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Both stages clear so that no condition shows before inputs settle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// ---- design/asw_bin2dec.sv ----
`timescale 1ns/1ps

// Serial double-dabble converter: 16-bit binary to five BCD digits.
module asw_bin2dec (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        start,
  input  wire logic [15:0] bin_in,
  output logic             done,
  output logic [19:0]      bcd_out
);

  logic [15:0] sh_q;
  logic [15:0] sh_d;
  logic [19:0] bcd_q;
  logic [19:0] bcd_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic        busy_q;
  logic        busy_d;
  logic        done_q;
  logic        done_d;
  logic [19:0] adj;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // One bit per cycle keeps the adder count at five small nibble adders.
  always_comb begin
    sh_d   = sh_q;
    bcd_d  = bcd_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    adj    = bcd_q;
    for (int i = 0; i < 5; i++) begin
      if (bcd_q[i*4 +: 4] > 4'h4) begin
        adj[i*4 +: 4] = bcd_q[i*4 +: 4] + 4'h3;
      end
    end
    if (start) begin
      sh_d   = bin_in;
      bcd_d  = '0;
      cnt_d  = 5'h10;
      busy_d = 1'b1;
    end else if (busy_q) begin
      bcd_d = {adj[18:0], sh_q[15]};
      sh_d  = {sh_q[14:0], 1'b0};
      cnt_d = cnt_q - 5'h01;
      if (cnt_q == 5'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sh_q   <= '0;
      bcd_q  <= '0;
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      sh_q   <= sh_d;
      bcd_q  <= bcd_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign done    = done_q;
  assign bcd_out = bcd_q;

endmodule

// ---- design/asw_alarm_status.sv ----
`timescale 1ns/1ps

module asw_alarm_status (
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic [15:0]           alarm_raw,
  input  wire logic                  alarm_clear,
  input  wire logic                  enable_req,
  input  wire logic                  sampling,
  input  wire logic                  in_position,
  input  wire logic                  moving,
  input  wire logic                  jogging,
  input  wire logic                  stopping,
  input  wire logic                  wait_input_cmd,
  input  wire logic                  saving,
  input  wire logic                  homing_cmd,
  input  wire logic                  timed_wait_cmd,
  input  wire logic                  wizard_run,
  input  wire logic                  wizard_enc_chk,
  input  wire logic                  program_run,
  input  wire logic                  initializing,
  input  wire logic                  query_valid,
  input  wire asw_pkg::asw_query_t   query_kind,
  output logic                       query_ready,
  output logic                       reply_valid,
  output logic [7:0]                 reply_char,
  output logic                       reply_last,
  input  wire logic                  reply_ready,
  output logic                       motor_enable,
  output logic                       fault_active,
  output logic [15:0]                alarm_word,
  output logic [15:0]                status_word
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [15:0] alarm_s;

  asw_sync #(.W(16)) u_alarm_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (alarm_raw),
    .sync_out (alarm_s)
  );

  // ----------------------------------------------------------------
  // Alarm word and motor enable
  // ----------------------------------------------------------------
  logic [15:0] alarm_q;
  logic [15:0] alarm_d;
  logic        en_q;
  logic        en_d;
  logic        fault;
  logic [15:0] status_w;

  // Alarms latch until cleared; a condition still present re-sets its bit,
  // so the set wins over a clear arriving in the same cycle.
  // Bits 2, 6 and 9 carry CW limit, under-voltage and encoder fault.
  always_comb begin
    alarm_d = alarm_q;
    if (alarm_clear) begin
      alarm_d = '0;
    end
    alarm_d = alarm_d | alarm_s;
    fault   = |(alarm_q & asw_pkg::ALM_FAULT_MASK);
    en_d    = enable_req;
    if (|(alarm_d & asw_pkg::ALM_FAULT_MASK)) begin
      en_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarm_q <= '0;
      en_q    <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
      en_q    <= en_d;
    end
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  // Status inputs come from logic on this clock and need no synchroniser.
  always_comb begin
    status_w                          = '0;
    status_w[asw_pkg::STS_ENABLED]    = en_q;
    status_w[asw_pkg::STS_SAMPLING]   = sampling;
    status_w[asw_pkg::STS_FAULT]      = fault;
    status_w[asw_pkg::STS_IN_POS]     = in_position;
    status_w[asw_pkg::STS_MOVING]     = moving;
    status_w[asw_pkg::STS_JOGGING]    = jogging;
    status_w[asw_pkg::STS_STOPPING]   = stopping;
    status_w[asw_pkg::STS_WAIT_INPUT] = wait_input_cmd;
    status_w[asw_pkg::STS_SAVING]     = saving;
    status_w[asw_pkg::STS_ALARM]      = |alarm_q;
    status_w[asw_pkg::STS_HOMING]     = homing_cmd;
    status_w[asw_pkg::STS_WAIT_TIME]  = timed_wait_cmd;
    status_w[asw_pkg::STS_WIZARD]     = wizard_run;
    status_w[asw_pkg::STS_ENC_CHECK]  = wizard_enc_chk;
    status_w[asw_pkg::STS_PROGRAM]    = program_run;
    status_w[asw_pkg::STS_INIT]       = initializing;
  end

  assign alarm_word   = alarm_q;
  assign status_word  = status_w;
  assign motor_enable = en_q;
  assign fault_active = fault;

  // ----------------------------------------------------------------
  // Reply engine
  // ----------------------------------------------------------------
  typedef enum {
    ASW_IDLE,
    ASW_CONV,
    ASW_PFX0,
    ASW_PFX1,
    ASW_PFX2,
    ASW_EQ,
    ASW_DIGIT,
    ASW_END
  } asw_state_t;

  asw_state_t          st_q;
  asw_state_t          st_d;
  asw_pkg::asw_query_t kind_q;
  asw_pkg::asw_query_t kind_d;
  logic [15:0]         snap_q;
  logic [15:0]         snap_d;
  logic [19:0]         dig_q;
  logic [19:0]         dig_d;
  logic [2:0]          idx_q;
  logic [2:0]          idx_d;
  logic                conv_start;
  logic                conv_done;
  logic [19:0]         conv_bcd;
  logic                is_dec;
  logic [3:0]          cur_nib;
  logic [7:0]          ch;
  logic [2:0]          first_idx;
  logic [2:0]          ndig;

  asw_bin2dec u_bin2dec (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (conv_start),
    .bin_in   (snap_q),
    .done     (conv_done),
    .bcd_out  (conv_bcd)
  );

  assign is_dec = (kind_q == asw_pkg::ASW_QRY_ALARM_DEC) ||
                  (kind_q == asw_pkg::ASW_QRY_STATE_DEC);

  // Highest non-zero digit; zero still sends one digit.
  always_comb begin
    ndig      = is_dec ? 3'(asw_pkg::DEC_DIGITS) : 3'h4;
    first_idx = 3'h0;
    for (int i = 0; i < 5; i++) begin
      if (3'(i) < ndig && dig_q[i*4 +: 4] != 4'h0) begin
        first_idx = 3'(i);
      end
    end
    cur_nib = dig_q[idx_q*4 +: 4];
    if (cur_nib > 4'h9) begin
      ch = {4'h0, cur_nib} + asw_pkg::CH_HEX_A;
    end else begin
      ch = {4'h0, cur_nib} + asw_pkg::CH_ZERO;
    end
  end

  // Query is taken only in idle; the host waits on query_ready.
  always_comb begin
    st_d        = st_q;
    kind_d      = kind_q;
    snap_d      = snap_q;
    dig_d       = dig_q;
    idx_d       = idx_q;
    conv_start  = 1'b0;
    reply_valid = 1'b0;
    reply_char  = 8'h00;
    reply_last  = 1'b0;
    query_ready = (st_q == ASW_IDLE);
    unique case (st_q)
      ASW_IDLE: begin
        if (query_valid) begin
          kind_d = query_kind;
          // One capture of the whole word keeps every bit coherent.
          if (query_kind == asw_pkg::ASW_QRY_ALARM_HEX ||
              query_kind == asw_pkg::ASW_QRY_ALARM_DEC) begin
            snap_d = alarm_q;
          end else begin
            snap_d = status_w;
          end
          st_d = ASW_CONV;
        end
      end
      ASW_CONV: begin
        if (!is_dec) begin
          dig_d = {4'h0, snap_q};
          st_d  = ASW_PFX0;
        end else if (idx_q == 3'h0) begin
          conv_start = 1'b1;
          idx_d      = 3'h1;
        end else if (conv_done) begin
          dig_d = conv_bcd;
          idx_d = 3'h0;
          st_d  = ASW_PFX0;
        end
      end
      ASW_PFX0: begin
        reply_valid = 1'b1;
        unique case (kind_q)
          asw_pkg::ASW_QRY_ALARM_HEX: reply_char = asw_pkg::ALM_PFX0;
          asw_pkg::ASW_QRY_STATE_HEX: reply_char = asw_pkg::STS_PFX0;
          default:                    reply_char = asw_pkg::RD_PFX0;
        endcase
        if (reply_ready) begin
          st_d = ASW_PFX1;
        end
      end
      ASW_PFX1: begin
        reply_valid = 1'b1;
        unique case (kind_q)
          asw_pkg::ASW_QRY_ALARM_HEX: reply_char = asw_pkg::ALM_PFX1;
          asw_pkg::ASW_QRY_STATE_HEX: reply_char = asw_pkg::STS_PFX1;
          default:                    reply_char = asw_pkg::RD_PFX1;
        endcase
        if (reply_ready) begin
          st_d = is_dec ? ASW_PFX2 : ASW_EQ;
        end
      end
      ASW_PFX2: begin
        reply_valid = 1'b1;
        reply_char  = (kind_q == asw_pkg::ASW_QRY_ALARM_DEC) ? asw_pkg::ALM_REG
                                                             : asw_pkg::STS_REG;
        if (reply_ready) begin
          st_d = ASW_EQ;
        end
      end
      ASW_EQ: begin
        reply_valid = 1'b1;
        reply_char  = asw_pkg::CH_EQUALS;
        if (reply_ready) begin
          idx_d = first_idx;
          st_d  = ASW_DIGIT;
        end
      end
      ASW_DIGIT: begin
        reply_valid = 1'b1;
        reply_char  = ch;
        if (reply_ready) begin
          if (idx_q == 3'h0) begin
            st_d = ASW_END;
          end else begin
            idx_d = idx_q - 3'h1;
          end
        end
      end
      ASW_END: begin
        reply_valid = 1'b1;
        reply_char  = asw_pkg::CH_CR;
        reply_last  = 1'b1;
        if (reply_ready) begin
          idx_d = 3'h0;
          st_d  = ASW_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Reply registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q   <= ASW_IDLE;
      kind_q <= asw_pkg::ASW_QRY_ALARM_HEX;
      snap_q <= '0;
      dig_q  <= '0;
      idx_q  <= '0;
    end else begin
      st_q   <= st_d;
      kind_q <= kind_d;
      snap_q <= snap_d;
      dig_q  <= dig_d;
      idx_q  <= idx_d;
    end
  end

endmodule

// ---- test/asw_props.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checker for the alarm and status word bank.
// ----------------------------------------------------------------
module asw_props (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic [15:0]         alarm_raw,
  input wire logic                alarm_clear,
  input wire logic                enable_req,
  input wire logic                sampling,
  input wire logic                in_position,
  input wire logic                moving,
  input wire logic                jogging,
  input wire logic                stopping,
  input wire logic                wait_input_cmd,
  input wire logic                saving,
  input wire logic                homing_cmd,
  input wire logic                timed_wait_cmd,
  input wire logic                wizard_run,
  input wire logic                wizard_enc_chk,
  input wire logic                program_run,
  input wire logic                initializing,
  input wire logic                query_valid,
  input wire asw_pkg::asw_query_t query_kind,
  input wire logic                query_ready,
  input wire logic                reply_valid,
  input wire logic [7:0]          reply_char,
  input wire logic                reply_last,
  input wire logic                reply_ready,
  input wire logic                motor_enable,
  input wire logic                fault_active,
  input wire logic [15:0]         alarm_word,
  input wire logic [15:0]         status_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // A raw level held over four edges has crossed the two-flop chain.
  sequence raw_held(int b);
    alarm_raw[b] [*4];
  endsequence
  sequence hex_take;
    query_valid && query_ready && !query_kind[1];
  endsequence
  sequence dec_take;
    query_valid && query_ready && query_kind[1];
  endsequence
  // Every reply opens with one of the three prefix letters.
  sequence first_char;
    reply_valid && (reply_char == asw_pkg::ALM_PFX0 || reply_char == asw_pkg::STS_PFX0 ||
                    reply_char == asw_pkg::RD_PFX0);
  endsequence

  cw_limit_a: assert property (raw_held(2) |-> alarm_word[2])
    else $error("cw limit alarm missing");
  under_volt_a: assert property (raw_held(6) |-> alarm_word[6])
    else $error("under voltage alarm missing");
  enc_fault_a: assert property (raw_held(9) |-> alarm_word[9])
    else $error("encoder alarm missing");
  alarm_hold_a: assert property (!$past(alarm_clear) && !$past(sys_rst) |->
    (alarm_word & $past(alarm_word)) == $past(alarm_word))
    else $error("alarm bit dropped without clear");
  fault_flag_a: assert property (fault_active == |(alarm_word & asw_pkg::ALM_FAULT_MASK))
    else $error("fault flag wrong");
  fault_off_a: assert property (fault_active |-> !motor_enable)
    else $error("motor enabled during fault");
  status_map_a: assert property (status_word == {initializing, program_run,
    wizard_enc_chk, wizard_run, timed_wait_cmd, homing_cmd, |alarm_word, saving,
    wait_input_cmd, stopping, jogging, moving, in_position, fault_active, sampling,
    motor_enable}) else $error("status word map wrong");
  hex_answer_a: assert property (hex_take |-> ##[1:2] first_char)
    else $error("hex reply late");
  dec_answer_a: assert property (dec_take |-> ##[2:30] first_char)
    else $error("decimal reply late");
  take_busy_a: assert property (query_valid && query_ready |=> !query_ready)
    else $error("second query accepted");
  reply_hold_a: assert property (reply_valid && !reply_ready |=>
    reply_valid && $stable(reply_char)) else $error("reply char not held");
  reply_end_a: assert property (reply_last |-> reply_valid && reply_char == asw_pkg::CH_CR)
    else $error("reply end not terminator");
  reply_excl_a: assert property (reply_valid |-> !query_ready)
    else $error("ready during reply");
endmodule

bind asw_alarm_status asw_props u_asw_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .alarm_raw(alarm_raw), .alarm_clear(alarm_clear),
  .enable_req(enable_req), .sampling(sampling), .in_position(in_position), .moving(moving),
  .jogging(jogging), .stopping(stopping), .wait_input_cmd(wait_input_cmd), .saving(saving),
  .homing_cmd(homing_cmd), .timed_wait_cmd(timed_wait_cmd), .wizard_run(wizard_run),
  .wizard_enc_chk(wizard_enc_chk), .program_run(program_run), .initializing(initializing),
  .query_valid(query_valid), .query_kind(query_kind), .query_ready(query_ready),
  .reply_valid(reply_valid), .reply_char(reply_char), .reply_last(reply_last),
  .reply_ready(reply_ready), .motor_enable(motor_enable), .fault_active(fault_active),
  .alarm_word(alarm_word), .status_word(status_word));

// ---- test/asw_host_model.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side: issues one query per go pulse and gathers the reply.
// ----------------------------------------------------------------
module asw_host_model (
  input wire logic                 core_clk,
  input wire logic                 sys_rst,
  input wire logic                 go,
  input wire asw_pkg::asw_query_t  kind,
  input wire logic                 slow,
  output asw_pkg::asw_query_t      query_kind,
  output logic                     query_valid,
  input wire logic                 query_ready,
  input wire logic                 reply_valid,
  input wire logic [7:0]           reply_char,
  input wire logic                 reply_last,
  output logic                     reply_ready,
  output logic                     busy,
  output logic [95:0]              rx_text
);
  // Request is held until taken; a slow host accepts every other cycle.
  always @(posedge core_clk) begin
    if (sys_rst) begin
      query_valid <= 1'b0;
      query_kind  <= asw_pkg::ASW_QRY_ALARM_HEX;
      reply_ready <= 1'b0;
      busy        <= 1'b0;
      rx_text     <= '0;
    end else begin
      if (go) begin
        query_valid <= 1'b1;
        query_kind  <= kind;
        busy        <= 1'b1;
        rx_text     <= '0;
      end else if (query_valid && query_ready) begin
        query_valid <= 1'b0;
      end
      reply_ready <= slow ? ~reply_ready : 1'b1;
      if (reply_valid && reply_ready) begin
        rx_text <= {rx_text[87:0], reply_char};
        if (reply_last) busy <= 1'b0;
      end
    end
  end
endmodule

// ---- test/test_alarm_status_words.sv ----
`timescale 1ns/1ps

module test_alarm_status_words;
  logic                core_clk;
  logic                sys_rst;
  logic [15:0]         alarm_raw;
  logic                alarm_clear;
  logic                enable_req;
  logic [15:0]         st_in;
  logic                go;
  logic                slow;
  asw_pkg::asw_query_t kind;
  asw_pkg::asw_query_t query_kind;
  logic                query_valid;
  logic                query_ready;
  logic                reply_valid;
  logic [7:0]          reply_char;
  logic                reply_last;
  logic                reply_ready;
  logic                motor_enable;
  logic                fault_active;
  logic [15:0]         alarm_word;
  logic [15:0]         status_word;
  logic                busy;
  logic [95:0]         rx_text;
  int                  n_fail;
  int                  cmp_count;
  int                  cyc = 0;
  // Echoed prefixes; every reply carries one of these ahead of its value.
  localparam logic [7:0]  CR    = asw_pkg::CH_CR;
  localparam logic [15:0] P_ALM = {asw_pkg::ALM_PFX0, asw_pkg::ALM_PFX1};
  localparam logic [15:0] P_STS = {asw_pkg::STS_PFX0, asw_pkg::STS_PFX1};
  localparam logic [23:0] P_RDA = {asw_pkg::RD_PFX0, asw_pkg::RD_PFX1, asw_pkg::ALM_REG};
  localparam logic [23:0] P_RDS = {asw_pkg::RD_PFX0, asw_pkg::RD_PFX1, asw_pkg::STS_REG};

  // Status inputs sit at their own bit positions of st_in.
  asw_alarm_status u_asw_alarm_status (
    .core_clk(core_clk), .sys_rst(sys_rst), .alarm_raw(alarm_raw), .alarm_clear(alarm_clear),
    .enable_req(enable_req), .sampling(st_in[1]), .in_position(st_in[3]), .moving(st_in[4]),
    .jogging(st_in[5]), .stopping(st_in[6]), .wait_input_cmd(st_in[7]), .saving(st_in[8]),
    .homing_cmd(st_in[10]), .timed_wait_cmd(st_in[11]), .wizard_run(st_in[12]),
    .wizard_enc_chk(st_in[13]), .program_run(st_in[14]), .initializing(st_in[15]),
    .query_valid(query_valid), .query_kind(query_kind), .query_ready(query_ready),
    .reply_valid(reply_valid), .reply_char(reply_char), .reply_last(reply_last),
    .reply_ready(reply_ready), .motor_enable(motor_enable), .fault_active(fault_active),
    .alarm_word(alarm_word), .status_word(status_word));

  asw_host_model u_asw_host_model (
    .core_clk(core_clk), .sys_rst(sys_rst), .go(go), .kind(kind), .slow(slow),
    .query_kind(query_kind), .query_valid(query_valid), .query_ready(query_ready),
    .reply_valid(reply_valid), .reply_char(reply_char), .reply_last(reply_last),
    .reply_ready(reply_ready), .busy(busy), .rx_text(rx_text));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One query; status inputs switch to nxt once taken, so a snapshot shows.
  task automatic query(input asw_pkg::asw_query_t k, input logic s, input logic [15:0] cur,
                       input logic [15:0] nxt, input logic [95:0] exp);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    kind <= k;
    slow <= s;
    st_in <= cur;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    n = 0;
    while (busy === 1'b1 && n < 100) begin
      @(posedge core_clk);
      if (query_ready === 1'b0) st_in <= nxt;
      #1;
      n++;
    end
    check("reply done", busy, 1'b0);
    check("reply", rx_text, exp);
  endtask

  // Alarm lines are held for four edges, then checked.
  task automatic set_alarm(input logic [15:0] raw, input logic clr);
    @(posedge core_clk);
    alarm_raw <= raw;
    alarm_clear <= clr;
    repeat (4) @(posedge core_clk);
    alarm_clear <= 1'b0;
    #1;
  endtask

  // Hang guard: the sequence needs well under a thousand cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end

  initial begin
    sys_rst = 1'b1;
    alarm_raw = 16'h0000;
    alarm_clear = 1'b0;
    enable_req = 1'b0;
    st_in = 16'h0000;
    go = 1'b0;
    slow = 1'b0;
    kind = asw_pkg::ASW_QRY_ALARM_HEX;
    n_fail = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    enable_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    check("enabled", status_word, 16'h0001);
    // Walk every input-driven status bit on its own.
    for (int p = 1; p < 16; p++) begin
      if (p != 2 && p != 9) begin
        @(posedge core_clk);
        st_in <= 16'h0001 << p;
        #1;
        check("status bit", status_word, 16'h0001 | (16'h0001 << p));
      end
    end
    @(posedge core_clk);
    st_in <= 16'h0000;
    set_alarm(16'h0244, 1'b0);
    check("alarm", alarm_word, 16'h0244);
    check("fault", fault_active, 1'b1);
    check("motor", motor_enable, 1'b0);
    check("fault status", status_word, 16'h0204);
    query(asw_pkg::ASW_QRY_ALARM_HEX, 1'b0, 16'h0000, 16'h0000, {P_ALM, "=244", CR});
    query(asw_pkg::ASW_QRY_ALARM_DEC, 1'b1, 16'h0000, 16'h0000, {P_RDA, "=580", CR});
    set_alarm(16'h0000, 1'b0);
    check("sticky", alarm_word, 16'h0244);
    set_alarm(16'h0040, 1'b1);
    check("under volt", status_word, 16'h0201);
    set_alarm(16'h0000, 1'b1);
    check("cleared", alarm_word, 16'h0000);
    query(asw_pkg::ASW_QRY_ALARM_HEX, 1'b1, 16'h0000, 16'h0000, {P_ALM, "=0", CR});
    query(asw_pkg::ASW_QRY_STATE_HEX, 1'b1, 16'h4088, 16'h0000, {P_STS, "=4089", CR});
    query(asw_pkg::ASW_QRY_STATE_DEC, 1'b0, 16'h4088, 16'h0010, {P_RDS, "=16521", CR});
    stop_test;
  end
endmodule
